// ==== fpv_pkg.sv ====
`default_nettype none
package fpv_pkg;
	// ========================================================
	// clock, command codes and retry limit
	localparam int         CLK_NS      = 25;
	localparam logic [7:0] CMD_PROG    = 8'h40;
	localparam logic [7:0] CMD_VERIFY  = 8'hc0;
	localparam logic [7:0] CMD_RESET   = 8'hff;
	localparam logic [7:0] CMD_READ    = 8'h00;
	localparam logic [4:0] MAX_TRIES   = 5'h19;

	// ========================================================
	// pin timing, figures as printed, counts derived
	localparam int  T_CS_NS    = 20;
	localparam int  T_WP_NS    = 60;
	localparam int  T_DH_NS    = 10;
	localparam int  T_WPH_NS   = 20;
	localparam real T_PROG_US  = 9.5;
	localparam real T_WHGL_US  = 6.0;
	localparam int  T_ACC_NS   = 120;
	localparam int  T_DF_NS    = 40;

	// least times round up, never below one cycle
	function automatic int fpv_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : fpv_cyc

	localparam int PROG_CYC = fpv_cyc(int'(T_PROG_US * 1000.0));
	localparam int WHGL_CYC = fpv_cyc(int'(T_WHGL_US * 1000.0));

	// timer loads are count minus one: state lasts count cycles
	localparam logic [8:0] TV_CS   = 9'(fpv_cyc(T_CS_NS) - 1);
	localparam logic [8:0] TV_WP   = 9'(fpv_cyc(T_WP_NS) - 1);
	localparam logic [8:0] TV_DH   = 9'(fpv_cyc(T_DH_NS) - 1);
	localparam logic [8:0] TV_WPH  = 9'(fpv_cyc(T_WPH_NS) - 1);
	localparam logic [8:0] TV_PROG = 9'(PROG_CYC - 1);
	localparam logic [8:0] TV_WHGL = 9'(WHGL_CYC - 1);
	localparam logic [8:0] TV_ACC  = 9'(fpv_cyc(T_ACC_NS) - 1);
	localparam logic [8:0] TV_DF   = 9'(fpv_cyc(T_DF_NS) - 1);

	// ========================================================
	// types
	typedef enum logic [1:0] {
		OP_READ    = 2'h0,
		OP_PROGRAM = 2'h1,
		OP_RESET   = 2'h2
	} fpv_op_t;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_WR_SETUP = 3'h1,
		ST_WR_PULSE = 3'h2,
		ST_WR_HOLD  = 3'h3,
		ST_WR_GAP   = 3'h4,
		ST_WAIT     = 3'h5,
		ST_RD_ACC   = 3'h6,
		ST_RD_END   = 3'h7
	} fpv_state_e_t;

	typedef enum logic [2:0] {
		STEP_PGM_SETUP = 3'h0,
		STEP_PGM_DATA  = 3'h1,
		STEP_VERIFY    = 3'h2,
		STEP_RST1      = 3'h3,
		STEP_RST2      = 3'h4,
		STEP_READCMD   = 3'h5,
		STEP_READ      = 3'h6
	} fpv_step_t;

	typedef struct packed {
		fpv_op_t     op;
		logic [14:0] addr;
		logic [7:0]  data;
	} fpv_req_t;

	typedef struct packed {
		logic       fail;
		logic [7:0] data;
	} fpv_rsp_t;

	typedef struct packed {
		fpv_state_e_t state;
		fpv_step_t    step;
		fpv_op_t      op;
		logic [14:0]  addr;
		logic [7:0]   data;
		logic [7:0]   rd_data;
		logic [4:0]   tries;
		logic         ce_n;
		logic         oe_n;
		logic         we_n;
		logic [7:0]   dq_out;
		logic         dq_oe;
		logic         rsp_valid;
		fpv_rsp_t     rsp;
	} fpv_state_t;

	localparam fpv_state_t STATE_RESET = '{
		state: ST_IDLE, step: STEP_READ, op: OP_READ,
		addr: 15'h0000, data: 8'h00, rd_data: 8'h00, tries: 5'h00,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0,
		rsp_valid: 1'b0, rsp: '{fail: 1'b0, data: 8'h00}
	};
endpackage : fpv_pkg
`default_nettype wire

// ==== fpv_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================================
// down counter: load on start, done once it reaches zero
module fpv_timer #(
	parameter int W = 9
) (
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	output logic              done
);
	logic [W-1:0] cnt;

	// counter, parked at zero when idle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
		end else if (start) begin
			cnt <= load;
		end else if (cnt != '0) begin
			cnt <= cnt - W'(1);
		end
	end

	assign done = (cnt == '0);
endmodule : fpv_timer
`default_nettype wire

// ==== fpv_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================================
// host sequencer: program/verify, reset and plain read
module fpv_host (
	input  wire logic            CLOCK,
	input  wire logic            RSTN,
	input  wire logic            REQ_VALID,
	output logic                 REQ_READY,
	input  wire fpv_pkg::fpv_req_t REQ,
	output logic                 RSP_VALID,
	output fpv_pkg::fpv_rsp_t    RSP,
	output logic                 FLASH_CE_N,
	output logic                 FLASH_OE_N,
	output logic                 FLASH_WE_N,
	output logic [14:0]          FLASH_ADDR,
	input  wire logic [7:0]      FLASH_DQ_IN,
	output logic [7:0]           FLASH_DQ_OUT,
	output logic                 FLASH_DQ_OE
);
	fpv_pkg::fpv_state_t s;
	fpv_pkg::fpv_state_t next_s;
	logic                tstart;
	logic [8:0]          tload;
	logic                tdone;

	// ========================================================
	// helpers that open a bus cycle or return to idle with a response
	function automatic fpv_pkg::fpv_state_t begin_write(input fpv_pkg::fpv_state_t x,
		input logic [7:0] d);
		x.state  = fpv_pkg::ST_WR_SETUP;
		x.ce_n   = 1'b0;
		x.dq_out = d;
		x.dq_oe  = 1'b1;
		return x;
	endfunction : begin_write

	function automatic fpv_pkg::fpv_state_t begin_read(input fpv_pkg::fpv_state_t x);
		x.state = fpv_pkg::ST_RD_ACC;
		x.ce_n  = 1'b0;
		x.oe_n  = 1'b0;
		x.dq_oe = 1'b0;
		return x;
	endfunction : begin_read

	function automatic fpv_pkg::fpv_state_t respond(input fpv_pkg::fpv_state_t x,
		input logic fail);
		x.state     = fpv_pkg::ST_IDLE;
		x.rsp_valid = 1'b1;
		x.rsp.fail  = fail;
		x.rsp.data  = x.rd_data;
		return x;
	endfunction : respond

	// ========================================================
	// next state
	always_comb begin
		next_s           = s;
		next_s.rsp_valid = 1'b0;
		unique case (s.state)
			fpv_pkg::ST_IDLE: begin
				if (REQ_VALID) begin
					next_s.op      = REQ.op;
					next_s.addr    = REQ.addr;
					next_s.data    = REQ.data;
					next_s.tries   = 5'h00;
					next_s.rd_data = 8'h00;
					case (REQ.op)
						fpv_pkg::OP_PROGRAM: begin
							next_s.step = fpv_pkg::STEP_PGM_SETUP;
							next_s = begin_write(next_s, fpv_pkg::CMD_PROG);
						end
						fpv_pkg::OP_RESET: begin
							next_s.step = fpv_pkg::STEP_RST1;
							next_s = begin_write(next_s, fpv_pkg::CMD_RESET);
						end
						default: begin
							next_s.step = fpv_pkg::STEP_READ;
							next_s = begin_read(next_s);
						end
					endcase
				end
			end
			fpv_pkg::ST_WR_SETUP: begin
				// strobe falls only once chip select has led
				if (tdone) begin
					next_s.state = fpv_pkg::ST_WR_PULSE;
					next_s.we_n  = 1'b0;
				end
			end
			fpv_pkg::ST_WR_PULSE: begin
				// rising strobe: device latches here (operand starts, verify stops)
				if (tdone) begin
					next_s.state = fpv_pkg::ST_WR_HOLD;
					next_s.we_n  = 1'b1;
				end
			end
			fpv_pkg::ST_WR_HOLD: begin
				// data held past the strobe before the bus is let go
				if (tdone) begin
					next_s.state = fpv_pkg::ST_WR_GAP;
					next_s.ce_n  = 1'b1;
					next_s.dq_oe = 1'b0;
				end
			end
			fpv_pkg::ST_WR_GAP: begin
				if (tdone) begin
					unique case (s.step)
						fpv_pkg::STEP_PGM_SETUP: begin
							// operand cycle: address and byte together
							next_s.step = fpv_pkg::STEP_PGM_DATA;
							next_s = begin_write(next_s, s.data);
						end
						fpv_pkg::STEP_PGM_DATA: next_s.state = fpv_pkg::ST_WAIT;
						fpv_pkg::STEP_VERIFY:   next_s.state = fpv_pkg::ST_WAIT;
						fpv_pkg::STEP_RST1: begin
							next_s.step = fpv_pkg::STEP_RST2;
							next_s = begin_write(next_s, fpv_pkg::CMD_RESET);
						end
						fpv_pkg::STEP_RST2: begin
							// leave the device in a known mode after reset
							next_s.step = fpv_pkg::STEP_READCMD;
							next_s = begin_write(next_s, fpv_pkg::CMD_READ);
						end
						default: next_s = respond(next_s, 1'b0);
					endcase
				end
			end
			fpv_pkg::ST_WAIT: begin
				if (tdone) begin
					if (s.step == fpv_pkg::STEP_PGM_DATA) begin
						// programming has run its minimum; now stop it
						next_s.step = fpv_pkg::STEP_VERIFY;
						next_s = begin_write(next_s, fpv_pkg::CMD_VERIFY);
					end else begin
						next_s = begin_read(next_s);
					end
				end
			end
			fpv_pkg::ST_RD_ACC: begin
				// address kept unchanged, so a verify read sees the latched byte
				if (tdone) begin
					next_s.state   = fpv_pkg::ST_RD_END;
					next_s.rd_data = FLASH_DQ_IN;
					next_s.ce_n    = 1'b1;
					next_s.oe_n    = 1'b1;
				end
			end
			fpv_pkg::ST_RD_END: begin
				// wait for the device to float the bus before anything else
				if (tdone) begin
					if (s.step != fpv_pkg::STEP_VERIFY) begin
						next_s = respond(next_s, 1'b0);
					end else if (s.rd_data == s.data) begin
						next_s = respond(next_s, 1'b0);
					end else if (s.tries < fpv_pkg::MAX_TRIES - 5'h01) begin
						next_s.tries = s.tries + 5'h01;
						next_s.step  = fpv_pkg::STEP_PGM_SETUP;
						next_s = begin_write(next_s, fpv_pkg::CMD_PROG);
					end else begin
						next_s = respond(next_s, 1'b1);
					end
				end
			end
		endcase
	end

	// ========================================================
	// timer restarts on every state change, length by the new state
	always_comb begin
		tstart = (next_s.state != s.state);
		unique case (next_s.state)
			fpv_pkg::ST_WR_SETUP: tload = fpv_pkg::TV_CS;
			fpv_pkg::ST_WR_PULSE: tload = fpv_pkg::TV_WP;
			fpv_pkg::ST_WR_HOLD:  tload = fpv_pkg::TV_DH;
			fpv_pkg::ST_WR_GAP:   tload = fpv_pkg::TV_WPH;
			fpv_pkg::ST_WAIT:     tload = (next_s.step == fpv_pkg::STEP_PGM_DATA) ?
				fpv_pkg::TV_PROG : fpv_pkg::TV_WHGL;
			fpv_pkg::ST_RD_ACC:   tload = fpv_pkg::TV_ACC;
			fpv_pkg::ST_RD_END:   tload = fpv_pkg::TV_DF;
			fpv_pkg::ST_IDLE:     tload = 9'h000;
		endcase
	end

	fpv_timer #(
		.W(9)
	) u_timer (
		.clock(CLOCK),
		.rstn (RSTN),
		.start(tstart),
		.load (tload),
		.done (tdone)
	);

	// state register
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			s <= fpv_pkg::STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign REQ_READY    = (s.state == fpv_pkg::ST_IDLE);
	assign RSP_VALID    = s.rsp_valid;
	assign RSP          = s.rsp;
	assign FLASH_CE_N   = s.ce_n;
	assign FLASH_OE_N   = s.oe_n;
	assign FLASH_WE_N   = s.we_n;
	assign FLASH_ADDR   = s.addr;
	assign FLASH_DQ_OUT = s.dq_out;
	assign FLASH_DQ_OE  = s.dq_oe;

	// ========================================================
	// checks; helper counts cycles the strobe has stayed high
	logic [11:0] since_we;

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			since_we <= 12'h000;
		end else if (!s.we_n) begin
			since_we <= 12'h000;
		end else if (since_we != 12'hfff) begin
			since_we <= since_we + 12'h001;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	sequence s_we_pulse;
		!FLASH_WE_N [*3] ##1 FLASH_WE_N;
	endsequence

	sequence s_we_fall(fpv_pkg::fpv_step_t st);
		$fell(FLASH_WE_N) && s.step == st;
	endsequence

	a_strobe_in_select: assert property (!FLASH_WE_N |-> !FLASH_CE_N)
		else $error("write strobe low without chip select");
	a_strobe_width: assert property ($fell(FLASH_WE_N) |-> s_we_pulse)
		else $error("write strobe pulse not three cycles");
	a_bus_no_fight: assert property (!FLASH_OE_N |-> !FLASH_DQ_OE && FLASH_WE_N)
		else $error("host drives data while reading");
	a_prog_code: assert property (s_we_fall(fpv_pkg::STEP_PGM_SETUP)
		|-> FLASH_DQ_OE && FLASH_DQ_OUT == fpv_pkg::CMD_PROG)
		else $error("program setup code wrong");
	a_verify_code: assert property (s_we_fall(fpv_pkg::STEP_VERIFY)
		|-> FLASH_DQ_OUT == fpv_pkg::CMD_VERIFY && since_we >= fpv_pkg::PROG_CYC)
		else $error("verify code wrong or programming cut short");
	// first reset write sits in its gap two cycles before the second strobe falls
	a_reset_twice: assert property (s_we_fall(fpv_pkg::STEP_RST2)
		|-> FLASH_DQ_OUT == fpv_pkg::CMD_RESET && $past(s.step, 2) == fpv_pkg::STEP_RST1
		&& $past(FLASH_DQ_OUT, 2) == fpv_pkg::CMD_RESET)
		else $error("reset code not written twice");
	a_read_after_rst: assert property (s_we_fall(fpv_pkg::STEP_READCMD)
		|-> FLASH_DQ_OUT == fpv_pkg::CMD_READ)
		else $error("reset not followed by read command");
	a_verify_read: assert property ($fell(FLASH_OE_N) && s.step == fpv_pkg::STEP_VERIFY
		|-> since_we >= fpv_pkg::WHGL_CYC)
		else $error("verify read too soon after strobe");
	a_pass_on_match: assert property (RSP_VALID && s.op == fpv_pkg::OP_PROGRAM && !RSP.fail
		|-> $past(s.step) == fpv_pkg::STEP_VERIFY && RSP.data == s.data)
		else $error("program reported good without matching verify");
endmodule : fpv_host
`default_nettype wire

// ==== fpv_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================================
// flash device: command register, program/verify, reset
module fpv_flash_model (
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [14:0] addr,
	input  wire logic [7:0]  dq_wr,
	input  wire logic [4:0]  bad_n,
	output logic      [7:0]  dq_rd,
	output int               progs,
	output int               resets,
	output int               viol
);
	typedef enum logic [2:0] {M_READ, M_PSET, M_PROG, M_VER, M_RST1} fpv_mode_t;
	fpv_mode_t   mode;
	logic [7:0]  mem [0:32767];
	logic [14:0] lat_a;
	logic [7:0]  lat_d;
	logic        busy;
	realtime     t0;
	int          vcount;
	// array preset to a pattern the bench can predict
	initial begin
		for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'h5a;
		{progs, resets, viol, vcount} = '0;
		mode = M_READ;
		busy = 1'b0;
	end
	// a write ends on whichever strobe rises while the other is low
	always @(posedge we_n or posedge ce_n) begin
		if (!ce_n || !we_n) begin
			if (mode == M_PSET) begin
				lat_a = addr;
				lat_d = dq_wr;
				busy = 1'b1;
				t0 = $realtime;
				mode = M_PROG;
				progs++;
			end else if (dq_wr == 8'h40) mode = M_PSET;
			else if (dq_wr == 8'hc0 && mode == M_PROG) begin
				if ($realtime - t0 < 9500.0) viol++;
				mem[lat_a] = lat_d;
				busy = 1'b0;
				mode = M_VER;
			end else if (dq_wr == 8'hff && mode == M_RST1) begin
				busy = 1'b0;
				vcount = 0;
				mode = M_READ;
				resets++;
			end else if (dq_wr == 8'hff) mode = M_RST1;
			else if (dq_wr == 8'h00) mode = M_READ;
			else viol++;
		end
	end
	// weak cells: the first bad_n verify reads come back inverted
	always @(posedge oe_n) if (mode == M_VER) vcount++;
	logic [7:0] rd;
	assign rd = (mode != M_VER) ? mem[addr] :
		(vcount < int'(bad_n)) ? ~mem[lat_a] : mem[lat_a];
	// released bus shows the inverse so stale data cannot pass
	assign dq_rd = (!ce_n && !oe_n && we_n) ? rd : ~rd;
endmodule : fpv_flash_model
`default_nettype wire

// ==== fpv_host_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpv_host_tb;
	logic              CLOCK = 1'b0;
	logic              RSTN = 1'b0;
	logic              REQ_VALID = 1'b0;
	fpv_pkg::fpv_req_t REQ = '0;
	logic              REQ_READY, RSP_VALID, CE_N, OE_N, WE_N, DQ_OE;
	fpv_pkg::fpv_rsp_t RSP;
	logic [14:0]       ADDR, a;
	logic [7:0]        DQ_IN, DQ_OUT, d;
	logic [4:0]        bad_n = 5'h00;
	logic [8:0]        exp_q[$];
	int                progs, resets, viol, p0;
	int                fail_count = 0;
	int                num_checks = 0;
	always #12.5 CLOCK = ~CLOCK;
	fpv_host dut (.CLOCK(CLOCK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
		.REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP), .FLASH_CE_N(CE_N), .FLASH_OE_N(OE_N),
		.FLASH_WE_N(WE_N), .FLASH_ADDR(ADDR), .FLASH_DQ_IN(DQ_IN), .FLASH_DQ_OUT(DQ_OUT),
		.FLASH_DQ_OE(DQ_OE));
	fpv_flash_model flash (.ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .addr(ADDR), .dq_wr(DQ_OUT),
		.bad_n(bad_n), .dq_rd(DQ_IN), .progs(progs), .resets(resets), .viol(viol));
	// ========================================================
	// comparison and verdict
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// ========================================================
	// driver: held until taken, expectation noted at issue
	task automatic send(input fpv_pkg::fpv_op_t op, input logic [14:0] ad,
		input logic [7:0] dt, input logic [8:0] e);
		REQ_VALID = 1'b1;
		REQ = '{op, ad, dt};
		exp_q.push_back(e);
		while (REQ_READY !== 1'b1) @(negedge CLOCK);
		@(negedge CLOCK);
	endtask : send
	task automatic idle();
		REQ_VALID = 1'b0;
		for (int i = 0; i < 40000 && exp_q.size() > 0; i++) @(negedge CLOCK);
		check(9'(exp_q.size()), 9'h000);
		@(negedge CLOCK);
	endtask : idle
	// monitor: every response takes the oldest note
	always @(negedge CLOCK) begin
		if (RSP_VALID === 1'b1) begin
			if (exp_q.size() == 0) check(9'(exp_q.size()), 9'h001);
			else check(RSP, exp_q.pop_front());
		end
	end
	// hang guard, well past the longest expected run
	initial begin
		repeat (80000) @(posedge CLOCK);
		fail_count++;
		final_report();
	end
	// ========================================================
	// scenarios
	initial begin
		logic [4:0] bads [3];
		int         tries [3];
		bads = '{5'h00, 5'h02, 5'h1f};
		tries = '{1, 3, 25};
		void'($urandom(32'hb6ca));
		repeat (16) @(negedge CLOCK);
		RSTN = 1'b1;
		@(negedge CLOCK);
		// back-to-back plain reads
		for (int i = 0; i < 4; i++) begin
			a = 15'($urandom);
			send(fpv_pkg::OP_READ, a, 8'($urandom), {1'b0, a[7:0] ^ 8'h5a});
		end
		idle();
		// program with clean, twice weak and never passing verifies
		for (int k = 0; k < 3; k++) begin
			bad_n = bads[k];
			p0 = progs;
			a = 15'($urandom);
			d = 8'($urandom);
			send(fpv_pkg::OP_RESET, a, 8'h00, 9'h000);
			send(fpv_pkg::OP_PROGRAM, a, d, (k == 2) ? {1'b1, ~d} : {1'b0, d});
			// no read command follows a verify, so a still weak byte reads back inverted
			send(fpv_pkg::OP_READ, a, 8'h00, {1'b0, (k == 2) ? ~d : d});
			idle();
			check(9'(progs - p0), 9'(tries[k]));
		end
		// async reset mid-program, then reset command must abandon it
		bad_n = 5'h00;
		a = 15'($urandom);
		send(fpv_pkg::OP_PROGRAM, a, 8'($urandom), 9'h000);
		REQ_VALID = 1'b0;
		repeat (200) @(negedge CLOCK);
		RSTN = 1'b0;
		exp_q.delete();
		@(negedge CLOCK);
		check({CE_N, WE_N, OE_N, DQ_OE}, 9'h00e);
		RSTN = 1'b1;
		@(negedge CLOCK);
		send(fpv_pkg::OP_RESET, a, 8'h00, 9'h000);
		send(fpv_pkg::OP_READ, a, 8'h00, {1'b0, a[7:0] ^ 8'h5a});
		idle();
		check(9'(flash.busy), 9'h000);
		check(9'(resets), 9'h004);
		check(9'(viol), 9'h000);
		final_report();
	end
endmodule : fpv_host_tb
`default_nettype wire
